// >>> verilog/emtc_pkg.sv
/*
  Package for the MAC test and frame-format configuration block.
  Holds register indices, field positions, reset values, the frame-plan
  constants and the carrier structs. Assumes a 32-bit AXI4-Lite bus.
*/
`default_nettype none
package emtc_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_TEST = 8'h20;
  localparam logic [7:0] IDX_CFG1 = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  localparam logic [9:0] ADDR_TEST = {IDX_TEST, 2'b00};
  localparam logic [9:0] ADDR_CFG1 = {IDX_CFG1, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_CFG1 = 8'h00;
  // Test register fields
  localparam int TB_FIFO_TEST = 6;
  localparam int TB_DIR_SEL = 5;
  localparam int TB_SHORT_SLOT = 4;
  localparam int TB_SIM_RESET = 3;
  localparam int TB_FORCE_OVR = 2;
  localparam int TB_FORCE_UND = 1;
  localparam int TB_LOOPBACK = 0;
  localparam logic [7:0] TEST_WR_MASK = 8'h7f;
  // Frame config one fields
  localparam int CB_PAD = 7;
  localparam int CB_AUTO = 6;
  localparam int CB_VLAN_PAD = 5;
  localparam int CB_CRC = 4;
  localparam int CB_FULL_DUPLEX = 3;
  localparam int CB_LEN_CHECK = 2;
  localparam int CB_OVERSIZE = 1;
  localparam int CB_HDR_SKIP = 0;
  // Frame plan constants
  localparam logic [15:0] VLAN_TAG = 16'h8100;
  localparam logic [15:0] MAX_LENGTH_FIELD = 16'h05dc;
  localparam logic [6:0] PAD_PLAIN = 7'h3c;
  localparam logic [6:0] PAD_VLAN = 7'h40;
  localparam logic [2:0] HDR_SKIP_BYTES = 3'h4;
  localparam logic [15:0] SLOT_NORMAL = 16'h0200;
  localparam logic [15:0] SLOT_SHORT = 16'h0010;
  localparam logic [1:0] RESP_OKAY = 2'b00;

  typedef struct packed {
    logic fifo_test;
    logic fifo_test_direction_select;
    logic short_slot_timer;
    logic simulation_reset;
    logic force_receive_overflow;
    logic force_transmit_starvation;
    logic internal_loopback;
  } emtc_test_s;

  typedef struct packed {
    logic [3:0] data;
    logic valid;
  } emtc_nibble_s;
endpackage : emtc_pkg
`default_nettype wire

// >>> verilog/emtc_config.sv
/*
  Test-mode and frame-format configuration of an embedded Ethernet MAC:
  AXI4-Lite register slave, pad/CRC frame plan, length checks, loopback.
  Assumes the MAC core samples the plan on frame start and honours the
  control levels; PHY receive pins are asynchronous to clk_in.
*/
// Operation
// - System reset restores every register default
// - Unmapped writes ignored, reads return zero
// - Test bit 6 enters FIFO test mode
// - Test bit 5 picks transmit or receive FIFO
// - Test bit 4 shortens the slot timer
// - Test bit 2 forces receive FIFO overrun
// - Test bit 1 forces transmit FIFO underrun
// - Test bit 0 loops transmit into receive
// - Pad enable appends zeros to short frames
// - Auto-detect compares type octets with 8100
// - VLAN pad pads to 64, adds CRC
// - CRC enable appends CRC to every frame
// - Config bit 3 selects full or half duplex
// - Config bit 2 checks length field
// - Config bit 1 lifts maximum frame limit
// - Config bit 0 skips four-byte header in CRC
// - Padding off: no pad, CRC only if enabled
// - Plain padding: pad 60, CRC, 64 minimum
// - VLAN pad, no auto: pad 64, minimum 68
// - Auto-detect: 60 or 64 by tag, CRC
`default_nettype none
module emtc_config #(
  parameter int MAX_LEN_BITS = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Transmit frame plan request
  input wire logic tx_frame_start_in,
  input wire logic [15:0] tx_type_field_in,
  output logic [6:0] pad_to_length_out,
  output logic crc_append_out,
  output logic vlan_detected_out,
  // Frame length checks
  input wire logic frame_end_in,
  input wire logic [15:0] frame_length_in,
  input wire logic [15:0] length_field_in,
  input wire logic [MAX_LEN_BITS-1:0] max_frame_length_in,
  output logic length_mismatch_out,
  output logic oversize_out,
  // Nibble paths: MAC transmit, PHY receive pins, MAC receive
  input wire emtc_pkg::emtc_nibble_s mac_tx_in,
  input wire emtc_pkg::emtc_nibble_s phy_rx_in,
  output emtc_pkg::emtc_nibble_s mac_rx_out,
  // Control levels to the MAC core
  output emtc_pkg::emtc_test_s test_ctrl_out,
  output logic [15:0] slot_time_count_out,
  output logic csma_enable_out,
  output logic [2:0] crc_skip_bytes_out
);
  if (MAX_LEN_BITS < 1 || MAX_LEN_BITS > 16) begin : g_bad_width
    $error("MAX_LEN_BITS must be 1..16");
  end

  logic rst_meta;
  logic rst_n;
  logic [7:0] test_reg;
  logic [7:0] cfg1;
  logic aw_held;
  logic w_held;
  logic [9:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic do_write;
  logic [31:0] next_rdata;
  logic hold_n;
  emtc_pkg::emtc_nibble_s rx_meta;
  emtc_pkg::emtc_nibble_s rx_sync;
  logic [6:0] next_pad;
  logic next_crc;
  logic next_vlan;
  logic pad_on;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_bresp = emtc_pkg::RESP_OKAY;
  assign s_axi_rresp = emtc_pkg::RESP_OKAY;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 10'h000;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr[9:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_byte <= s_axi_wdata[7:0];
        wr_lane <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Registers; bit 7 of the test register has no storage
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      test_reg <= emtc_pkg::RST_TEST;
      cfg1 <= emtc_pkg::RST_CFG1;
    end else if (do_write && wr_lane) begin
      if (wr_addr == emtc_pkg::ADDR_TEST) begin
        test_reg <= wr_byte & emtc_pkg::TEST_WR_MASK;
      end else if (wr_addr == emtc_pkg::ADDR_CFG1) begin
        cfg1 <= wr_byte;
      end
    end
  end

  // Read channel: one word at a time, unmapped reads return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (s_axi_araddr[9:0])
      emtc_pkg::ADDR_TEST: next_rdata = {24'h00_0000, test_reg};
      emtc_pkg::ADDR_CFG1: next_rdata = {24'h00_0000, cfg1};
      emtc_pkg::ADDR_STATUS: next_rdata = {28'h000_0000, vlan_detected_out,
        length_mismatch_out, oversize_out, crc_append_out};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Test controls to the core
  always_comb begin
    test_ctrl_out.fifo_test = test_reg[emtc_pkg::TB_FIFO_TEST];
    test_ctrl_out.fifo_test_direction_select =
      test_reg[emtc_pkg::TB_FIFO_TEST] & test_reg[emtc_pkg::TB_DIR_SEL];
    test_ctrl_out.short_slot_timer = test_reg[emtc_pkg::TB_SHORT_SLOT];
    test_ctrl_out.simulation_reset = test_reg[emtc_pkg::TB_SIM_RESET];
    test_ctrl_out.force_receive_overflow = test_reg[emtc_pkg::TB_FORCE_OVR];
    test_ctrl_out.force_transmit_starvation = test_reg[emtc_pkg::TB_FORCE_UND];
    test_ctrl_out.internal_loopback = test_reg[emtc_pkg::TB_LOOPBACK];
  end

  assign slot_time_count_out = test_reg[emtc_pkg::TB_SHORT_SLOT] ?
    emtc_pkg::SLOT_SHORT : emtc_pkg::SLOT_NORMAL;
  assign csma_enable_out = !cfg1[emtc_pkg::CB_FULL_DUPLEX];
  assign crc_skip_bytes_out = cfg1[emtc_pkg::CB_HDR_SKIP] ?
    emtc_pkg::HDR_SKIP_BYTES : 3'h0;

  // Plan, length flags and receive output stay in reset while simulation reset is set
  assign hold_n = rst_n && !test_reg[emtc_pkg::TB_SIM_RESET];

  // Pad and CRC decision from the four high config bits
  assign pad_on = cfg1[emtc_pkg::CB_PAD];
  always_comb begin
    next_vlan = cfg1[emtc_pkg::CB_AUTO] && (tx_type_field_in == emtc_pkg::VLAN_TAG);
    next_pad = 7'h00;
    next_crc = cfg1[emtc_pkg::CB_CRC];
    if (pad_on) begin
      next_crc = 1'b1;
      if (cfg1[emtc_pkg::CB_AUTO]) begin
        next_pad = next_vlan ? emtc_pkg::PAD_VLAN : emtc_pkg::PAD_PLAIN;
      end else if (cfg1[emtc_pkg::CB_VLAN_PAD]) begin
        next_pad = emtc_pkg::PAD_VLAN;
      end else begin
        next_pad = emtc_pkg::PAD_PLAIN;
      end
    end
    if (!pad_on) begin
      next_vlan = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge hold_n) begin
    if (!hold_n) begin
      pad_to_length_out <= 7'h00;
      crc_append_out <= 1'b0;
      vlan_detected_out <= 1'b0;
    end else if (tx_frame_start_in) begin
      pad_to_length_out <= next_pad;
      crc_append_out <= next_crc;
      vlan_detected_out <= next_vlan;
    end
  end

  // Length checks at frame end; results stand until the next end
  always_ff @(posedge clk_in or negedge hold_n) begin
    if (!hold_n) begin
      length_mismatch_out <= 1'b0;
      oversize_out <= 1'b0;
    end else if (frame_end_in) begin
      length_mismatch_out <= cfg1[emtc_pkg::CB_LEN_CHECK] &&
        (length_field_in <= emtc_pkg::MAX_LENGTH_FIELD) &&
        (length_field_in != frame_length_in);
      oversize_out <= !cfg1[emtc_pkg::CB_OVERSIZE] &&
        (frame_length_in > 16'(max_frame_length_in));
    end
  end

  // PHY pins pass two flops; loopback picks the same-clock transmit nibble
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= '0;
      rx_sync <= '0;
    end else begin
      rx_meta <= phy_rx_in;
      rx_sync <= rx_meta;
    end
  end

  always_ff @(posedge clk_in or negedge hold_n) begin
    if (!hold_n) begin
      mac_rx_out <= '0;
    end else begin
      mac_rx_out <= test_reg[emtc_pkg::TB_LOOPBACK] ? mac_tx_in : rx_sync;
    end
  end

  // Checks
  sequence s_write_taken;
    do_write;
  endsequence
  sequence s_write_answer;
    ##1 s_axi_bvalid;
  endsequence

  chk_write_answer: assert property (@(posedge clk_in) disable iff (!rst_n)
    s_write_taken |-> s_write_answer)
    else $error("write not answered next cycle");
  chk_test_top_bit: assert property (@(posedge clk_in) disable iff (!rst_n)
    test_reg[7] == 1'b0)
    else $error("reserved test bit became set");
  chk_unmapped_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:0] != emtc_pkg::ADDR_TEST &&
     s_axi_araddr[9:0] != emtc_pkg::ADDR_CFG1 && s_axi_araddr[9:0] != emtc_pkg::ADDR_STATUS)
    |=> (s_axi_rvalid && s_axi_rdata == 32'h0000_0000))
    else $error("unmapped read returned nonzero");
  chk_pad_off_plan: assert property (@(posedge clk_in) disable iff (!hold_n)
    (tx_frame_start_in && hold_n && !pad_on) |=>
      (pad_to_length_out == 7'h00 && crc_append_out == $past(cfg1[emtc_pkg::CB_CRC])))
    else $error("pad applied with padding off");
  chk_pad_vlan_len: assert property (@(posedge clk_in) disable iff (!hold_n)
    (tx_frame_start_in && hold_n && pad_on && cfg1[emtc_pkg::CB_AUTO] &&
     tx_type_field_in == 16'h8100) |=> (pad_to_length_out == 7'h40 && crc_append_out))
    else $error("detected VLAN frame not padded to 64");
  chk_pad_plain_len: assert property (@(posedge clk_in) disable iff (!hold_n)
    (tx_frame_start_in && hold_n && cfg1[7:5] == 3'b100) |=>
      (pad_to_length_out == 7'h3c && crc_append_out))
    else $error("plain padding not 60 with CRC");
  chk_duplex_csma: assert property (@(posedge clk_in) disable iff (!rst_n)
    $rose(cfg1[emtc_pkg::CB_FULL_DUPLEX]) |-> !csma_enable_out)
    else $error("collision logic left on in full duplex");
  chk_loopback_path: assert property (@(posedge clk_in) disable iff (!hold_n)
    test_reg[0] && $past(test_reg[0]) && $past(hold_n) |-> mac_rx_out == $past(mac_tx_in))
    else $error("loopback did not route transmit nibble");
  chk_oversize_flag: assert property (@(posedge clk_in) disable iff (!hold_n)
    (frame_end_in && cfg1[1]) |=> !oversize_out)
    else $error("oversize flagged while unlimited frames allowed");
  chk_sim_reset_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
    test_reg[3] [*2] |-> (pad_to_length_out == 7'h00 && !length_mismatch_out))
    else $error("state not held under simulation reset");

  // Read answers come from rst_n logic, so simulation reset does not disable the read and write checks; plan, length and rx path checks use hold_n
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_read_answer;
    ##1 (s_axi_rvalid && s_axi_rresp == emtc_pkg::RESP_OKAY);
  endsequence

  chk_read_answer: assert property (@(posedge clk_in) disable iff (!rst_n)
    s_read_taken |-> s_read_answer)
    else $error("read not answered next cycle");
  chk_test_write_land: assert property (@(posedge clk_in) disable iff (!rst_n)
    (do_write && wr_lane && wr_addr == emtc_pkg::ADDR_TEST) |=>
      (test_reg == ($past(wr_byte) & emtc_pkg::TEST_WR_MASK)))
    else $error("test register write did not land");
  chk_cfg_write_land: assert property (@(posedge clk_in) disable iff (!rst_n)
    (do_write && wr_lane && wr_addr == emtc_pkg::ADDR_CFG1) |=> (cfg1 == $past(wr_byte)))
    else $error("config register write did not land");
  chk_unmapped_write: assert property (@(posedge clk_in) disable iff (!rst_n)
    (do_write && wr_addr != emtc_pkg::ADDR_TEST && wr_addr != emtc_pkg::ADDR_CFG1) |=>
      ($stable(test_reg) && $stable(cfg1)))
    else $error("unmapped write changed a register");
  chk_vlan_pad_fixed: assert property (@(posedge clk_in) disable iff (!hold_n)
    (tx_frame_start_in && hold_n && cfg1[7:5] == 3'b101) |=>
      (pad_to_length_out == 7'h40 && crc_append_out))
    else $error("VLAN padding not 64 with CRC");
  chk_crc_forced: assert property (@(posedge clk_in) disable iff (!hold_n)
    (tx_frame_start_in && hold_n && cfg1[emtc_pkg::CB_CRC]) |=> crc_append_out)
    else $error("CRC not appended with CRC enable set");
  chk_vlan_needs_pad: assert property (@(posedge clk_in) disable iff (!hold_n)
    (tx_frame_start_in && hold_n && !pad_on) |=> !vlan_detected_out)
    else $error("VLAN flagged with padding off");
  chk_length_ignored: assert property (@(posedge clk_in) disable iff (!hold_n)
    (frame_end_in && hold_n && !cfg1[emtc_pkg::CB_LEN_CHECK]) |=> !length_mismatch_out)
    else $error("length mismatch flagged with check off");
  chk_slot_short: assert property (@(posedge clk_in) disable iff (!rst_n)
    test_reg[emtc_pkg::TB_SHORT_SLOT] |-> slot_time_count_out == emtc_pkg::SLOT_SHORT)
    else $error("slot timer not shortened");
  chk_rx_pin_path: assert property (@(posedge clk_in) disable iff (!hold_n)
    (!test_reg[0] && !$past(test_reg[0]) && $past(hold_n)) |-> mac_rx_out == $past(rx_sync))
    else $error("receive path not fed from pins");
endmodule : emtc_config
`default_nettype wire

// >>> tb/emtc_phy_model.sv
/*
  Behavioural receive side of the line transceiver for the config bench.
  Assumes one clock shared with the bench; a send pulse starts an 8-nibble burst.
*/
`default_nettype none
module emtc_phy_model (
  // Clock and request
  input wire logic clk_in,
  input wire logic send_in,
  // Receive pins
  output var emtc_pkg::emtc_nibble_s phy_rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  initial phy_rx_out = '0;
  always @(posedge clk_in) begin
    if (send_in) begin
      left <= 8;
    end else if (left > 0) begin
      left <= left - 1;
    end
    if (left > 0) begin
      phy_rx_out <= '{data: left[3:0] ^ 4'h3, valid: 1'b1};
    end else begin
      // Idle data toggles every cycle so a value one cycle stale cannot pass for fresh data
      phy_rx_out <= '{data: ~phy_rx_out.data, valid: 1'b0};
    end
  end
endmodule : emtc_phy_model
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench for the MAC test and frame-format configuration block.
  Assumes the package constants and the transceiver model beside it.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, reset_n_in = 0, phy_send = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_frame_start_in = 0, frame_end_in = 0, crc_append_out;
  logic vlan_detected_out, length_mismatch_out, oversize_out, csma_enable_out;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] tx_type_field_in = 0, frame_length_in = 0, length_field_in = 0;
  logic [15:0] max_frame_length_in = 0, slot_time_count_out;
  logic [6:0] pad_to_length_out;
  logic [2:0] crc_skip_bytes_out;
  emtc_pkg::emtc_nibble_s mac_tx_in = '0, phy_rx_in, mac_rx_out;
  emtc_pkg::emtc_test_s test_ctrl_out;
  int fails = 0, checks = 0;
  always #4 clk_in = ~clk_in;
  emtc_config u_dut (.clk_in, .reset_n_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .tx_frame_start_in, .tx_type_field_in, .pad_to_length_out,
    .crc_append_out, .vlan_detected_out, .frame_end_in, .frame_length_in, .length_field_in,
    .max_frame_length_in, .length_mismatch_out, .oversize_out, .mac_tx_in, .phy_rx_in,
    .mac_rx_out, .test_ctrl_out, .slot_time_count_out, .csma_enable_out, .crc_skip_bytes_out);
  emtc_phy_model u_phy (.clk_in, .send_in(phy_send), .phy_rx_out(phy_rx_in));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic axw(input logic [9:0] a, input logic [7:0] d);
    logic aw, w, ah, wh;
    aw = 1;
    w = 1;
    @(posedge clk_in);
    s_axi_awaddr <= {22'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(negedge clk_in);
      ah = aw && s_axi_awready;
      wh = w && s_axi_wready;
      @(posedge clk_in);
      if (ah) aw = 0;
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) w = 0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    do @(negedge clk_in); while (!s_axi_bvalid);
    @(posedge clk_in);
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_in);
    s_axi_araddr <= {22'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_in); while (!s_axi_arready);
    @(posedge clk_in);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_in); while (!s_axi_rvalid);
    @(posedge clk_in);
    d = s_axi_rdata;
    chk("rresp", 32'h0, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic plan(input logic [15:0] t);
    @(posedge clk_in);
    tx_type_field_in <= t;
    tx_frame_start_in <= 1'b1;
    @(posedge clk_in);
    tx_frame_start_in <= 1'b0;
    @(negedge clk_in);
  endtask : plan
  task automatic frm(input logic [15:0] l, input logic [15:0] f, input logic [15:0] m);
    @(posedge clk_in);
    frame_length_in <= l;
    length_field_in <= f;
    max_frame_length_in <= m;
    frame_end_in <= 1'b1;
    @(posedge clk_in);
    frame_end_in <= 1'b0;
    @(negedge clk_in);
  endtask : frm
  task automatic t_defaults;
    axr(emtc_pkg::ADDR_TEST, rd);
    chk("test_reg", 32'h0, rd);
    axr(emtc_pkg::ADDR_CFG1, rd);
    chk("cfg1_reg", 32'h0, rd);
    chk("slot", 32'h200, {16'h0, slot_time_count_out});
    chk("csma", 32'h1, {31'h0, csma_enable_out});
  endtask : t_defaults
  task automatic t_test_reg;
    axw(emtc_pkg::ADDR_TEST, 8'hff);
    axr(emtc_pkg::ADDR_TEST, rd);
    chk("test_rd", 32'h7f, rd);
    chk("ctrl", 32'h7f, {25'h0, test_ctrl_out});
    chk("slot_short", 32'h10, {16'h0, slot_time_count_out});
    axw(emtc_pkg::ADDR_TEST, 8'h20);
    chk("ctrl_gated", 32'h0, {25'h0, test_ctrl_out});
    axw(10'h08c, 8'h5a);
    axr(10'h08c, rd);
    chk("unmapped", 32'h0, rd);
    s_axi_wstrb <= 4'he;
    axw(emtc_pkg::ADDR_TEST, 8'h10);
    s_axi_wstrb <= 4'hf;
    axr(emtc_pkg::ADDR_TEST, rd);
    chk("test_kept", 32'h20, rd);
    axw(emtc_pkg::ADDR_TEST, 8'h00);
  endtask : t_test_reg
  task automatic t_pad_table;
    logic [6:0] p;
    for (int m = 0; m < 16; m++) begin
      axw(emtc_pkg::ADDR_CFG1, {m[3:0], 4'h0});
      for (int v = 0; v < 2; v++) begin
        plan(v[0] ? emtc_pkg::VLAN_TAG : 16'h0800);
        p = !m[3] ? 7'h0 : (m[2] ? (v[0] ? 7'h40 : 7'h3c) : (m[1] ? 7'h40 : 7'h3c));
        chk("pad", {25'h0, p}, {25'h0, pad_to_length_out});
        chk("crc", {31'h0, m[3] | m[0]}, {31'h0, crc_append_out});
        chk("vlan", {31'h0, m[3] & m[2] & v[0]}, {31'h0, vlan_detected_out});
      end
    end
  endtask : t_pad_table
  task automatic t_length;
    axw(emtc_pkg::ADDR_CFG1, 8'h0f);
    chk("csma_full", 32'h0, {31'h0, csma_enable_out});
    chk("skip", 32'h4, {29'h0, crc_skip_bytes_out});
    frm(16'd100, 16'd50, 16'd1518);
    chk("len_bad", 32'h1, {31'h0, length_mismatch_out});
    axr(emtc_pkg::ADDR_STATUS, rd);
    chk("status", 32'hd, rd);
    frm(16'd100, 16'h0600, 16'd1518);
    chk("len_type", 32'h0, {31'h0, length_mismatch_out});
    frm(16'd2000, 16'h0800, 16'd1518);
    chk("huge_ok", 32'h0, {31'h0, oversize_out});
    axw(emtc_pkg::ADDR_CFG1, 8'h00);
    chk("skip_off", 32'h0, {29'h0, crc_skip_bytes_out});
    frm(16'd100, 16'd50, 16'd1518);
    chk("len_off", 32'h0, {31'h0, length_mismatch_out});
    frm(16'd1519, 16'h0800, 16'd1518);
    chk("oversize", 32'h1, {31'h0, oversize_out});
    frm(16'd1518, 16'h0800, 16'd1518);
    chk("at_max", 32'h0, {31'h0, oversize_out});
  endtask : t_length
  task automatic t_paths(input logic lp);
    emtc_pkg::emtc_nibble_s q[$];
    int d;
    d = lp ? 1 : 3;
    axw(emtc_pkg::ADDR_TEST, {7'h0, lp});
    for (int i = 0; i < 12; i++) begin
      mac_tx_in <= '{data: i[3:0] ^ 4'h9, valid: 1'b1};
      phy_send <= (i == 0) && !lp;
      @(negedge clk_in);
      q.push_back(lp ? mac_tx_in : phy_rx_in);
      if (i >= d) chk("rx_path", {27'h0, q[i - d]}, {27'h0, mac_rx_out});
      @(posedge clk_in);
    end
    mac_tx_in <= '0;
  endtask : t_paths
  task automatic t_sim_reset;
    axw(emtc_pkg::ADDR_CFG1, 8'h80);
    axw(emtc_pkg::ADDR_TEST, 8'h08);
    plan(16'h0800);
    chk("held_pad", 32'h0, {25'h0, pad_to_length_out});
    axw(emtc_pkg::ADDR_TEST, 8'h00);
    plan(16'h0800);
    chk("free_pad", 32'h3c, {25'h0, pad_to_length_out});
    axw(emtc_pkg::ADDR_CFG1, 8'hff);
    axw(emtc_pkg::ADDR_TEST, 8'h15);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    axr(emtc_pkg::ADDR_CFG1, rd);
    chk("cfg1_rst", 32'h0, rd);
    axr(emtc_pkg::ADDR_TEST, rd);
    chk("test_rst", 32'h0, rd);
  endtask : t_sim_reset
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_defaults;
    t_test_reg;
    t_pad_table;
    t_length;
    t_paths(1'b1);
    t_paths(1'b0);
    t_sim_reset;
    end_sim;
  end
endmodule : tb
`default_nettype wire
